//--- rtl/ocd_pkg.sv
package ocd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_A_COUNTS = 9'h190;
  localparam logic [8:0] IDX_A_CTRL   = 9'h191;
  localparam logic [8:0] IDX_A_ROUTE  = 9'h192;
  localparam logic [8:0] IDX_B_COUNTS = 9'h196;
  localparam logic [8:0] IDX_B_CTRL   = 9'h197;
  localparam logic [8:0] IDX_B_ROUTE  = 9'h198;
  localparam logic [8:0] IDX_STATUS   = 9'h1a0;

  // Field positions
  localparam int CNT_LOW_LSB   = 4;
  localparam int CNT_HIGH_LSB  = 0;
  localparam int CTL_BYPASS    = 7;
  localparam int CTL_NOALIGN   = 6;
  localparam int CTL_FORCE     = 5;
  localparam int CTL_START     = 4;
  localparam int CTL_PHASE_LSB = 0;
  localparam int RT_DIRECT     = 1;
  localparam int RT_DCC_OFF    = 0;
  localparam int CNT_W         = 4;

  // Reset values
  localparam logic [7:0] RST_COUNTS = 8'h00;
  localparam logic [7:0] RST_CTRL_A = 8'h80;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_ROUTE  = 8'h00;

  // Distribution source select codes
  localparam logic [1:0] SRC_EXT = 2'b00;
  localparam logic [1:0] SRC_OSC = 2'b10;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {RD_IDLE, RD_VALID} ocd_rd_e;

  typedef struct packed {
    logic             bypass;
    logic             ignore_align;
    logic             force_high;
    logic             start_high;
    logic [CNT_W-1:0] phase;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic             direct;
    logic             dcc_off;
  } ocd_cfg_s;

  function automatic ocd_cfg_s ocd_unpack(input logic [7:0] cnts, input logic [7:0] ctl,
                                          input logic [7:0] rt);
    ocd_cfg_s c;
    c.bypass       = ctl[CTL_BYPASS];
    c.ignore_align = ctl[CTL_NOALIGN];
    c.force_high   = ctl[CTL_FORCE];
    c.start_high   = ctl[CTL_START];
    c.phase        = ctl[CTL_PHASE_LSB +: CNT_W];
    c.low_cnt      = cnts[CNT_LOW_LSB +: CNT_W];
    c.high_cnt     = cnts[CNT_HIGH_LSB +: CNT_W];
    c.direct       = rt[RT_DIRECT];
    c.dcc_off      = rt[RT_DCC_OFF];
    return c;
  endfunction

endpackage

//--- rtl/ocd_divider.sv
module ocd_divider (
  // Clock, reset, enable
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // Settings and alignment request
  input  wire ocd_pkg::ocd_cfg_s i_cfg,
  input  wire logic             i_align,
  // Divided level
  output logic                  o_div
);

  logic                     align_hit;
  logic                     div;
  logic                     next_div;
  logic [ocd_pkg::CNT_W-1:0] cnt;
  logic [ocd_pkg::CNT_W-1:0] next_cnt;
  logic [ocd_pkg::CNT_W-1:0] phase_cnt;
  logic [ocd_pkg::CNT_W-1:0] next_phase;

  assign align_hit = i_align && !i_cfg.ignore_align;

  always_comb
  begin
    next_div   = div;
    next_cnt   = cnt;
    next_phase = phase_cnt;
    if (i_cfg.bypass)
    begin
      next_div   = !div;
      next_cnt   = '0;
      next_phase = '0;
    end
    else if (align_hit)
    begin
      next_div   = i_cfg.start_high;
      next_phase = i_cfg.phase;
      next_cnt   = i_cfg.start_high ? i_cfg.high_cnt : i_cfg.low_cnt;
    end
    else if (phase_cnt != '0)
      next_phase = phase_cnt - 4'h1;
    else if (cnt != '0)
      next_cnt = cnt - 4'h1;
    else
    begin
      next_div = !div;
      next_cnt = div ? i_cfg.low_cnt : i_cfg.high_cnt;
    end
  end

  always_ff @(posedge i_clk)
    if (i_rst)
    begin
      div       <= 1'b0;
      cnt       <= '0;
      phase_cnt <= '0;
    end
    else if (i_ce)
    begin
      div       <= next_div;
      cnt       <= next_cnt;
      phase_cnt <= next_phase;
    end

  // Static high only with both force and ignore bits set
  always_ff @(posedge i_clk)
    if (i_rst)
      o_div <= 1'b0;
    else if (i_ce)
      o_div <= (i_cfg.ignore_align && i_cfg.force_high) ? 1'b1 : next_div;

  // Run-length tracking for the checks below
  ocd_pkg::ocd_cfg_s cfg_q;
  logic [5:0]        run;
  logic              clean;
  logic              toggle_ok;

  assign toggle_ok = i_ce && clean && !i_cfg.bypass && !align_hit && phase_cnt == '0
                     && cnt == '0 && i_cfg == cfg_q;

  always_ff @(posedge i_clk)
    if (i_rst)
    begin
      cfg_q <= '0;
      run   <= 6'h01;
      clean <= 1'b0;
    end
    else if (i_ce)
    begin
      cfg_q <= i_cfg;
      run   <= (next_div != div) ? 6'h01 : run + 6'h01;
      if (align_hit || i_cfg.bypass || i_cfg != cfg_q)
        clean <= 1'b0;
      else if (phase_cnt == '0 && cnt == '0)
        clean <= 1'b1;
    end

  sequence s_sync_delay1;
    i_ce && align_hit && !i_cfg.bypass && i_cfg.phase == 4'h1 && !i_cfg.start_high;
  endsequence

  sequence s_quiet2;
    (i_ce && !align_hit && !i_cfg.bypass) [*2];
  endsequence

  high_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
    toggle_ok && div |-> run == {2'b00, i_cfg.high_cnt} + 6'h01)
    else $error("high time differs from high count plus one");

  low_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
    toggle_ok && !div |-> run == {2'b00, i_cfg.low_cnt} + 6'h01)
    else $error("low time differs from low count plus one");

  bypass_tgl_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_cfg.bypass |=> div != $past(div))
    else $error("bypassed divider did not follow input clock");

  align_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && align_hit && !i_cfg.bypass |=>
      div == $past(i_cfg.start_high) && phase_cnt == $past(i_cfg.phase))
    else $error("alignment did not restart divider");

  force_lvl_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_cfg.ignore_align && i_cfg.force_high |=> o_div)
    else $error("forced level not high");

  phase_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_sync_delay1 ##1 s_quiet2 |-> !div)
    else $error("phase offset did not delay output");

endmodule // ocd_divider

//--- rtl/ocd_top.sv
// Overview of operation
// - Low time lasts low count plus one
// - High time lasts high count plus one
// - Bypass passes input clock straight through
// - Bypass resets set on A, clear on B
// - Alignment obeyed unless ignore bit or bypass bit set
// - Forced high level needs force and ignore bits both set
// - Start bit picks initial output level
// - Phase field delays output by input cycles
// - Direct route, select 10 feeds oscillator
// - Direct route, select 00 feeds external
// - Select 01 leaves divider driving pair
// - Direct bit clear keeps divider on pair
// - Channel B routes its pair likewise
// - Duty correction off only when bit set
module ocd_top #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  // Clock sources and alignment
  input  wire logic              i_osc_clk,
  input  wire logic              i_ext_clk,
  input  wire logic [1:0]        i_src_sel,
  input  wire logic              i_align,
  // Write address channel
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  // Write data channel
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  // Write response channel
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  // Read data channel
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Output pairs
  output logic                   o_pair_a_out_p,
  output logic                   o_pair_a_out_n,
  output logic                   o_pair_b_out_p,
  output logic                   o_pair_b_out_n,
  // Duty correction disables to drivers
  output logic                   o_duty_correction_disable_a,
  output logic                   o_duty_correction_disable_b
);

  localparam logic [2:0] SEL_STATUS = 3'h6;
  localparam logic [2:0] SEL_NONE   = 3'h7;

  // Maps a byte address onto a register slot
  function automatic logic [2:0] ocd_decode(input logic [ADDR_W-1:0] addr);
    logic [8:0] idx;
    idx = addr[10:2];
    if (addr[ADDR_W-1:11] != '0)
      return SEL_NONE;
    case (idx)
      ocd_pkg::IDX_A_COUNTS: return 3'h0;
      ocd_pkg::IDX_A_CTRL:   return 3'h1;
      ocd_pkg::IDX_A_ROUTE:  return 3'h2;
      ocd_pkg::IDX_B_COUNTS: return 3'h3;
      ocd_pkg::IDX_B_CTRL:   return 3'h4;
      ocd_pkg::IDX_B_ROUTE:  return 3'h5;
      ocd_pkg::IDX_STATUS:   return SEL_STATUS;
      default:               return SEL_NONE;
    endcase
  endfunction

  function automatic logic [7:0] ocd_reset_val(input int slot);
    case (slot)
      1:       return ocd_pkg::RST_CTRL_A;
      4:       return ocd_pkg::RST_CTRL_B;
      2, 5:    return ocd_pkg::RST_ROUTE;
      default: return ocd_pkg::RST_COUNTS;
    endcase
  endfunction

  logic [7:0]          regs [6];
  ocd_pkg::ocd_cfg_s   cfg_a;
  ocd_pkg::ocd_cfg_s   cfg_b;
  logic                div_a;
  logic                div_b;
  logic [ADDR_W-1:0]   awaddr_q;
  logic [7:0]          wdata_q;
  logic                wstrb_q;
  logic                aw_got;
  logic                w_got;
  logic                wr_fire;
  logic [2:0]          wr_sel;
  logic [2:0]          rd_sel;
  ocd_pkg::ocd_rd_e    rd_state;

  // Register storage, unpacked into per-channel settings
  assign cfg_a = ocd_pkg::ocd_unpack(regs[0], regs[1], regs[2]);
  assign cfg_b = ocd_pkg::ocd_unpack(regs[3], regs[4], regs[5]);

  assign wr_sel  = ocd_decode(awaddr_q);
  assign rd_sel  = ocd_decode(i_araddr);
  assign wr_fire = aw_got && w_got && !o_bvalid;

  // Write address and data taken in either order
  always_ff @(posedge i_clk)
    if (i_rst)
    begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= ocd_pkg::RESP_OKAY;
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wstrb_q   <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_awvalid && o_awready)
      begin
        awaddr_q  <= i_awaddr;
        aw_got    <= 1'b1;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        wdata_q  <= i_wdata[7:0];
        wstrb_q  <= i_wstrb[0];
        w_got    <= 1'b1;
        o_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= (wr_sel == SEL_NONE) ? ocd_pkg::RESP_SLVERR : ocd_pkg::RESP_OKAY;
        aw_got   <= 1'b0;
        w_got    <= 1'b0;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end

  // Register file; status and upper bits are read only
  always_ff @(posedge i_clk)
    if (i_rst)
    begin
      for (int i = 0; i < 6; i++)
        regs[i] <= ocd_reset_val(i);
    end
    else if (i_ce && wr_fire && wstrb_q && wr_sel < SEL_STATUS)
    begin
      if (wr_sel == 3'h2 || wr_sel == 3'h5)
        regs[wr_sel] <= {6'h00, wdata_q[1:0]};
      else
        regs[wr_sel] <= wdata_q;
    end

  // Read channel
  always_ff @(posedge i_clk)
    if (i_rst)
    begin
      rd_state  <= ocd_pkg::RD_IDLE;
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= ocd_pkg::RESP_OKAY;
    end
    else if (i_ce)
    begin
      case (rd_state)
        ocd_pkg::RD_IDLE:
        begin
          if (i_arvalid)
          begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            rd_state  <= ocd_pkg::RD_VALID;
            o_rresp   <= (rd_sel == SEL_NONE) ? ocd_pkg::RESP_SLVERR : ocd_pkg::RESP_OKAY;
            if (rd_sel == SEL_STATUS)
              o_rdata <= {28'h0000_000, o_pair_b_out_p, o_pair_a_out_p, div_b, div_a};
            else if (rd_sel == SEL_NONE)
              o_rdata <= 32'h0000_0000;
            else
              o_rdata <= {24'h00_0000, regs[rd_sel]};
          end
        end
        ocd_pkg::RD_VALID:
        begin
          if (i_rready)
          begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
            rd_state  <= ocd_pkg::RD_IDLE;
          end
        end
        default:
        begin
          rd_state  <= ocd_pkg::RD_IDLE;
          o_rvalid  <= 1'b0;
          o_arready <= 1'b1;
        end
      endcase
    end

  // Channel dividers
  ocd_divider u_div_a (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_cfg   (cfg_a),
    .i_align (i_align),
    .o_div   (div_a)
  );

  ocd_divider u_div_b (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_cfg   (cfg_b),
    .i_align (i_align),
    .o_div   (div_b)
  );

  // Picks the level for a pair from divider or a direct source
  function automatic logic ocd_route(input logic direct, input logic [1:0] sel,
                                     input logic osc, input logic ext, input logic dv);
    if (direct && sel == ocd_pkg::SRC_OSC)
      return osc;
    else if (direct && sel == ocd_pkg::SRC_EXT)
      return ext;
    return dv;
  endfunction

  logic next_a;
  logic next_b;

  assign next_a = ocd_route(cfg_a.direct, i_src_sel, i_osc_clk, i_ext_clk, div_a);
  assign next_b = ocd_route(cfg_b.direct, i_src_sel, i_osc_clk, i_ext_clk, div_b);

  always_ff @(posedge i_clk)
    if (i_rst)
    begin
      o_pair_a_out_p <= 1'b0;
      o_pair_a_out_n <= 1'b1;
      o_pair_b_out_p <= 1'b0;
      o_pair_b_out_n <= 1'b1;
    end
    else if (i_ce)
    begin
      o_pair_a_out_p <= next_a;
      o_pair_a_out_n <= !next_a;
      o_pair_b_out_p <= next_b;
      o_pair_b_out_n <= !next_b;
    end

  always_ff @(posedge i_clk)
    if (i_rst)
    begin
      o_duty_correction_disable_a <= 1'b0;
      o_duty_correction_disable_b <= 1'b0;
    end
    else if (i_ce)
    begin
      o_duty_correction_disable_a <= cfg_a.dcc_off;
      o_duty_correction_disable_b <= cfg_b.dcc_off;
    end

  reset_bypass_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rst) |-> cfg_a.bypass && !cfg_b.bypass && !cfg_a.ignore_align && !cfg_b.direct)
    else $error("bypass reset values wrong");

  osc_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && cfg_a.direct && i_src_sel == 2'b10 |=>
      o_pair_a_out_p == $past(i_osc_clk) && o_pair_a_out_n != o_pair_a_out_p)
    else $error("pair A not fed by oscillator");

  ext_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && cfg_a.direct && i_src_sel == 2'b00 |=> o_pair_a_out_p == $past(i_ext_clk))
    else $error("pair A not fed by external clock");

  div_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && (!cfg_a.direct || i_src_sel == 2'b01) |=> o_pair_a_out_p == $past(div_a))
    else $error("pair A not fed by its divider");

  chan_b_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && cfg_b.direct && i_src_sel == 2'b10 |=>
      o_pair_b_out_p == $past(i_osc_clk) && o_pair_b_out_n == !$past(i_osc_clk))
    else $error("pair B not fed by oscillator");

  dcc_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && wr_fire && wstrb_q && wr_sel == 3'h5 ##1 i_ce |=>
      o_duty_correction_disable_b == $past(wdata_q[0], 2))
    else $error("duty correction disable not applied");

  bresp_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before taken");

endmodule // ocd_top

//--- sim/ocd_src_model.sv
module ocd_src_model (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Source levels, selected outside the block
  output logic      o_osc_clk,
  output logic      o_ext_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] osc_cnt;
  logic [2:0] ext_cnt;

  // Oscillator level flips every 3 cycles
  always_ff @(posedge i_clk)
  begin
    if (i_rst || osc_cnt == 2'h2)
      osc_cnt <= 2'h0;
    else
      osc_cnt <= osc_cnt + 2'h1;
    if (i_rst)
      o_osc_clk <= 1'b0;
    else if (osc_cnt == 2'h2)
      o_osc_clk <= ~o_osc_clk;
  end

  // External level flips every 5 cycles
  always_ff @(posedge i_clk)
  begin
    if (i_rst || ext_cnt == 3'h4)
      ext_cnt <= 3'h0;
    else
      ext_cnt <= ext_cnt + 3'h1;
    if (i_rst)
      o_ext_clk <= 1'b1;
    else if (ext_cnt == 3'h4)
      o_ext_clk <= ~o_ext_clk;
  end
endmodule // ocd_src_model

//--- sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, align, awvalid, wvalid, bready, arvalid, rready;
  logic [1:0]  src_sel;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  wire         osc, ext, awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         pa_p, pa_n, pb_p, pb_n, dcc_a, dcc_b;
  int          mismatches, n_compared, cycles, n, i;
  logic [8:0]  idx_tab [6] = '{9'h190, 9'h191, 9'h192, 9'h196, 9'h197, 9'h198};
  logic [7:0]  rst_tab [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [1:0]  sel_tab [4] = '{2'b00, 2'b10, 2'b01, 2'b11};

  ocd_src_model u_ocd_src_model (.i_clk(clk), .i_rst(rst), .o_osc_clk(osc), .o_ext_clk(ext));

  ocd_top u_ocd_top (
    .i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_osc_clk(osc), .i_ext_clk(ext),
    .i_src_sel(src_sel), .i_align(align),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_pair_a_out_p(pa_p), .o_pair_a_out_n(pa_n), .o_pair_b_out_p(pb_p),
    .o_pair_b_out_n(pb_n), .o_duty_correction_disable_a(dcc_a),
    .o_duty_correction_disable_b(dcc_b)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    n_compared++;
    if (got != exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  function automatic logic [11:0] ba(input logic [8:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction

  function automatic logic pv(input logic b);
    return b ? pb_p : pa_p;
  endfunction

  function automatic logic src_lvl();
    return (src_sel == ocd_pkg::SRC_OSC) ? osc : ext;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_val({30'h0, bresp}, {30'h0, resp});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk_val(rdata, exp);
    chk_val({30'h0, rresp}, {30'h0, resp});
  endtask

  // Length of the next full run of the given level
  task automatic run_len(input logic b, input logic lvl, input int exp);
    int k;
    k = 0;
    @(negedge clk);
    while (pv(b) === lvl)
      @(negedge clk);
    while (pv(b) !== lvl)
      @(negedge clk);
    while (pv(b) === lvl)
    begin
      k++;
      @(negedge clk);
    end
    chk_n(k, exp);
  endtask

  task automatic toggles(input logic b, input int cyc, output int t);
    logic prev;
    t = 0;
    @(negedge clk);
    prev = pv(b);
    repeat (cyc)
    begin
      @(negedge clk);
      if (pv(b) !== prev)
        t++;
      prev = pv(b);
    end
  endtask

  task automatic follow(input logic b, output int miss);
    logic prev;
    miss = 0;
    @(negedge clk);
    prev = src_lvl();
    repeat (16)
    begin
      @(negedge clk);
      if (pv(b) !== prev)
        miss++;
      prev = src_lvl();
    end
  endtask

  // Restart channel B with alignment, then time its first run
  task automatic align_run(input logic [7:0] ctl, input logic lvl, input int exp);
    int k;
    wr(ba(ocd_pkg::IDX_B_CTRL), ctl, ocd_pkg::RESP_OKAY);
    @(posedge clk);
    align <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_val({31'h0, pb_p}, {31'h0, lvl});
    @(posedge clk);
    align <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
      @(negedge clk);
    end
    while (pb_p === lvl && k < 40);
    chk_n(k, exp);
  endtask

  initial
  begin
    {rst, align, awvalid, wvalid, bready, arvalid, rready} = 7'b1000000;
    {src_sel, awaddr, araddr, wdata} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++)
      rd(ba(idx_tab[i]), {24'h0, rst_tab[i]}, ocd_pkg::RESP_OKAY);
    chk_val({30'h0, dcc_a, dcc_b}, 32'h0);
    chk_val({31'h0, pa_n}, {31'h0, ~pa_p});
    toggles(1'b0, 8, n);
    chk_n(n, 8);
    run_len(1'b1, 1'b1, 1);
    run_len(1'b1, 1'b0, 1);
    wr(ba(ocd_pkg::IDX_B_COUNTS), 8'h21, ocd_pkg::RESP_OKAY);
    rd(ba(ocd_pkg::IDX_B_COUNTS), 32'h21, ocd_pkg::RESP_OKAY);
    run_len(1'b1, 1'b1, 2);
    run_len(1'b1, 1'b0, 3);
    wr(ba(ocd_pkg::IDX_B_COUNTS), 8'hf0, ocd_pkg::RESP_OKAY);
    run_len(1'b1, 1'b0, 16);
    run_len(1'b1, 1'b1, 1);
    wr(ba(ocd_pkg::IDX_A_CTRL), 8'h00, ocd_pkg::RESP_OKAY);
    wr(ba(ocd_pkg::IDX_A_COUNTS), 8'h13, ocd_pkg::RESP_OKAY);
    run_len(1'b0, 1'b1, 4);
    run_len(1'b0, 1'b0, 2);
    wr(ba(ocd_pkg::IDX_B_COUNTS), 8'h11, ocd_pkg::RESP_OKAY);
    // First run: phase, then count plus one, then one pair flop
    align_run(8'h13, 1'b1, 6);
    align_run(8'h03, 1'b0, 6);
    align_run(8'h01, 1'b0, 4);
    wr(ba(ocd_pkg::IDX_B_CTRL), 8'h53, ocd_pkg::RESP_OKAY);
    @(posedge clk);
    align <= 1'b1;
    toggles(1'b1, 12, n);
    chk_n(n > 0, 1);
    @(posedge clk);
    align <= 1'b0;
    wr(ba(ocd_pkg::IDX_B_CTRL), 8'h60, ocd_pkg::RESP_OKAY);
    // Let the forced level reach the pair before watching it
    repeat (2) @(posedge clk);
    toggles(1'b1, 10, n);
    chk_n(n, 0);
    chk_val({30'h0, pb_p, pb_n}, 32'h2);
    wr(ba(ocd_pkg::IDX_A_CTRL), 8'h60, ocd_pkg::RESP_OKAY);
    rd(ba(ocd_pkg::IDX_STATUS), 32'hf, ocd_pkg::RESP_OKAY);
    wr(ba(ocd_pkg::IDX_B_CTRL), 8'h40, ocd_pkg::RESP_OKAY);
    toggles(1'b1, 10, n);
    chk_n(n > 0, 1);
    wr(ba(ocd_pkg::IDX_B_CTRL), 8'h00, ocd_pkg::RESP_OKAY);
    wr(ba(ocd_pkg::IDX_B_COUNTS), 8'h00, ocd_pkg::RESP_OKAY);
    wr(ba(ocd_pkg::IDX_A_CTRL), 8'h80, ocd_pkg::RESP_OKAY);
    wr(ba(ocd_pkg::IDX_A_ROUTE), 8'hff, ocd_pkg::RESP_OKAY);
    rd(ba(ocd_pkg::IDX_A_ROUTE), 32'h03, ocd_pkg::RESP_OKAY);
    wr(ba(ocd_pkg::IDX_B_ROUTE), 8'h02, ocd_pkg::RESP_OKAY);
    chk_val({30'h0, dcc_a, dcc_b}, 32'h2);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      src_sel <= sel_tab[i];
      repeat (4) @(posedge clk);
      follow(1'b0, n);
      chk_n(n == 0, i < 2);
      follow(1'b1, n);
      chk_n(n == 0, i < 2);
    end
    wr(ba(ocd_pkg::IDX_A_ROUTE), 8'h00, ocd_pkg::RESP_OKAY);
    @(posedge clk);
    src_sel <= ocd_pkg::SRC_OSC;
    repeat (4) @(posedge clk);
    follow(1'b0, n);
    chk_n(n > 0, 1);
    wr(ba(ocd_pkg::IDX_B_ROUTE), 8'h01, ocd_pkg::RESP_OKAY);
    @(posedge clk);
    chk_val({30'h0, dcc_a, dcc_b}, 32'h1);
    wr(12'h840, 8'h55, ocd_pkg::RESP_SLVERR);
    rd(12'h840, 32'h0, ocd_pkg::RESP_SLVERR);
    wr(ba(ocd_pkg::IDX_STATUS), 8'hff, ocd_pkg::RESP_OKAY);
    test_done();
  end
endmodule // tb
